// [rtl/tpt_timer.v]
// Three channel 16-bit pulse timer with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "tpt_defines.vh"
module tpt_timer
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Avalon-MM slave
    input wire [15:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // Timer pins, count direction and ch2 B output
    input wire [2:0] count_down_pin,
    input wire ch1_a_pin,
    input wire ch2_b_pin,
    output reg ch2_b_out,
    output reg ch2_b_oe,
    // Requests
    output wire [2:0] adc_start,
    output wire [2:0] chan_irq,
    output wire irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [7:0] control [0:2];
    reg [7:0] mode [0:2];
    reg [7:0] io_control [0:2];
    reg [7:0] io_low0;
    reg [7:0] irq_enable [0:2];
    reg [7:0] flags [0:2];
    reg [15:0] count [0:2];
    reg [15:0] gra [0:2];
    reg [15:0] grb [0:2];
    reg [15:0] grc0;
    reg [15:0] grd0;
    reg [2:0] sync_reg;
    reg [2:0] ovf_seen;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg ack;
    reg [2:0] dn_meta, dn_sync;
    reg ca_meta, ca_sync, ca_prev;
    reg cb_meta, cb_sync, cb_prev;
    wire [2:0] clr_req;
    wire [2:0] ovf_evt;
    wire [2:0] match_a;
    wire [2:0] match_b;
    wire [2:0] sync_clr;
    wire [2:0] own_clr;
    wire c0_event;
    wire ch1_cap;
    wire ch2_cap;
    wire any_sync_clr;
    wire bus_wr;
    wire bus_rd;
    reg [31:0] next_readdata;
    genvar gi;
    // Single cycle wait state: answer on second cycle
    assign waitrequest = (read | write) & ~ack;
    assign bus_wr = write & ack;
    assign bus_rd = read & ack;
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            dn_meta <= 3'h0;
            dn_sync <= 3'h0;
            ca_meta <= 1'b0;
            ca_sync <= 1'b0;
            ca_prev <= 1'b0;
            cb_meta <= 1'b0;
            cb_sync <= 1'b0;
            cb_prev <= 1'b0;
        end
        else
        begin
            dn_meta <= count_down_pin;
            dn_sync <= dn_meta;
            ca_meta <= ch1_a_pin;
            ca_sync <= ca_meta;
            ca_prev <= ca_sync;
            cb_meta <= ch2_b_pin;
            cb_sync <= cb_meta;
            cb_prev <= cb_sync;
        end
    end
    // Ch0 C register compare event, unless used as buffer
    assign c0_event = (count[0] == grc0) & ~mode[0][`TPT_MODE_BUFC_BIT];
    // Ch1 capture from pin rising edge or ch0 C event
    assign ch1_cap = io_control[1][`TPT_IO1_SRC_BIT] ? c0_event : (ca_sync & ~ca_prev);
    // Ch2 B capture edge select
    assign ch2_cap = io_control[2][`TPT_IO_CAPTURE_BIT] &
        (io_control[2][`TPT_IO_BOTH_BIT] ? (cb_sync ^ cb_prev) :
        (io_control[2][0] ? (~cb_sync & cb_prev) : (cb_sync & ~cb_prev)));
    // ----------------------------------------
    // Per channel compare and clear logic
    // ----------------------------------------
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_ch
            wire [1:0] cclr;
            wire down_ok;
            wire c0_clear;
            assign cclr = control[gi][`TPT_CCLR_HI:`TPT_CCLR_LO];
            assign match_a[gi] = (gi == 1) ? ((count[gi] == gra[gi]) | ch1_cap) :
                (count[gi] == gra[gi]);
            assign match_b[gi] = (gi == 2) ?
                (io_control[2][`TPT_IO_CAPTURE_BIT] ? ch2_cap : (count[gi] == grb[gi])) :
                (count[gi] == grb[gi]);
            // Ch0 C/D clear only when not buffering
            assign c0_clear = (gi == 0) & control[0][`TPT_CCLR_C_BIT] &
                ((cclr == `TPT_CCLR_A) ? ~mode[0][`TPT_MODE_BUFC_BIT] & (count[0] == grc0) :
                (cclr == `TPT_CCLR_B) ? ~mode[0][`TPT_MODE_BUFD_BIT] & (count[0] == grd0) :
                1'b0);
            // Own clear source kept apart so the sync clear has no loop
            assign own_clr[gi] = ((gi == 0) & control[0][`TPT_CCLR_C_BIT]) ? c0_clear :
                (cclr == `TPT_CCLR_A) ? match_a[gi] :
                (cclr == `TPT_CCLR_B) ? match_b[gi] : 1'b0;
            assign sync_clr[gi] = sync_reg[gi] & own_clr[gi];
            assign clr_req[gi] = own_clr[gi] | ((cclr == `TPT_CCLR_SYNC) &
                ~((gi == 0) & control[0][`TPT_CCLR_C_BIT]) & sync_reg[gi] & any_sync_clr);
            // Down counting only in phase counting or cascade mode
            assign down_ok = (gi != 0) & (mode[gi][`TPT_MODE_PHASE_BIT] |
                mode[gi][`TPT_MODE_EXT_BIT]) & dn_sync[gi];
            assign ovf_evt[gi] = ~down_ok & ~clr_req[gi] & (count[gi] == `TPT_COUNT_MAX);
            // Interrupt and A/D start requests
            assign chan_irq[gi] = |(flags[gi] & irq_enable[gi] & 8'h1F);
            assign adc_start[gi] = irq_enable[gi][`TPT_ADC_EN_BIT] & match_a[gi];
            always @(posedge clk)
            begin
                if (!rst_n)
                    count[gi] <= `TPT_COUNT_ZERO;
                else if (bus_wr && address == `TPT_CH0_COUNT + gi * `TPT_CH_STRIDE)
                    count[gi] <= writedata[15:0];
                else if (clr_req[gi])
                    count[gi] <= `TPT_COUNT_ZERO;
                else if (down_ok)
                    count[gi] <= count[gi] - 16'h0001;
                else
                    count[gi] <= count[gi] + 16'h0001;
            end
        end
    endgenerate
    // Any synchronised channel that clears from its own source
    assign any_sync_clr = |sync_clr;
    assign irq = |(irq_status & irq_mask);
    // ----------------------------------------
    // Register writes and flags
    // ----------------------------------------
    integer i;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack <= 1'b0;
            sync_reg <= 3'h0;
            ovf_seen <= 3'h0;
            irq_status <= 3'h0;
            irq_mask <= 3'h0;
            io_low0 <= `TPT_BYTE_ZERO;
            grc0 <= `TPT_COUNT_MAX;
            grd0 <= `TPT_COUNT_MAX;
            for (i = 0; i < 3; i = i + 1)
            begin
                control[i] <= `TPT_BYTE_ZERO;
                mode[i] <= `TPT_BYTE_ZERO;
                io_control[i] <= `TPT_BYTE_ZERO;
                irq_enable[i] <= `TPT_BYTE_ZERO;
                flags[i] <= `TPT_BYTE_ZERO;
                gra[i] <= `TPT_COUNT_MAX;
                grb[i] <= `TPT_COUNT_MAX;
            end
        end
        else
        begin
            ack <= (read | write) & ~ack;
            if (bus_wr && address == `TPT_SYNC_REG)
                sync_reg <= writedata[2:0];
            if (bus_wr && address == `TPT_IRQ_MASK)
                irq_mask <= writedata[2:0];
            if (bus_wr && address == `TPT_CH0_IO_LOW)
                io_low0 <= writedata[7:0];
            if (bus_wr && address == `TPT_GRC0)
                grc0 <= writedata[15:0];
            if (bus_wr && address == `TPT_GRD0)
                grd0 <= writedata[15:0];
            // Chip status: set wins over write-one clear
            irq_status <= (irq_status & ~((bus_wr && address == `TPT_IRQ_STATUS) ?
                writedata[2:0] : 3'h0)) | ovf_evt;
            for (i = 0; i < 3; i = i + 1)
            begin
                if (bus_wr && address == `TPT_CH0_CONTROL + i * `TPT_CH_STRIDE)
                    control[i] <= writedata[7:0];
                if (bus_wr && address == `TPT_CH0_MODE + i * `TPT_CH_STRIDE)
                    mode[i] <= (i == 0) ? writedata[7:0] :
                        (writedata[7:0] & ~(8'h01 << `TPT_MODE_RSV_BIT));
                if (bus_wr && address == `TPT_CH0_IO_HIGH + i * `TPT_CH_STRIDE)
                    io_control[i] <= writedata[7:0];
                if (bus_wr && address == `TPT_CH0_IRQ_ENABLE + i * `TPT_CH_STRIDE)
                    irq_enable[i] <= writedata[7:0];
                if (bus_wr && address == `TPT_GRA_BASE + i * `TPT_GR_STRIDE)
                    gra[i] <= writedata[15:0];
                if (bus_wr && address == `TPT_GRB_BASE + i * `TPT_GR_STRIDE)
                    grb[i] <= writedata[15:0];
                // Read of overflow as one arms its clear
                if (bus_rd && address == `TPT_CH0_FLAGS + i * `TPT_CH_STRIDE)
                    ovf_seen[i] <= flags[i][`TPT_OVF_BIT];
                // Zero writes clear only; ones ignored; events win
                if (bus_wr && address == `TPT_CH0_FLAGS + i * `TPT_CH_STRIDE)
                begin
                    flags[i] <= (flags[i] & (writedata[7:0] |
                        ~({3'h0, ovf_seen[i], 4'hF} & 8'h1F))) |
                        ({3'h0, ovf_evt[i], 4'h0}) |
                        ({6'h0, match_b[i], match_a[i]});
                    ovf_seen[i] <= 1'b0;
                end
                else
                    flags[i] <= flags[i] | {3'h0, ovf_evt[i], 2'h0, match_b[i], match_a[i]};
            end
        end
    end
    // ----------------------------------------
    // Channel 2 B pin output compare
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch2_b_out <= 1'b0;
            ch2_b_oe <= 1'b0;
        end
        else if (io_control[2][`TPT_IO_CAPTURE_BIT] ||
            io_control[2][`TPT_IO_LOW_HI:0] == `TPT_IO_OFF)
            ch2_b_oe <= 1'b0;
        else if (!ch2_b_oe)
        begin
            ch2_b_oe <= 1'b1;
            ch2_b_out <= io_control[2][`TPT_IO_INIT_BIT];
        end
        else if (count[2] == grb[2])
        begin
            case (io_control[2][`TPT_IO_LOW_HI:0])
                `TPT_IO_ZERO: ch2_b_out <= 1'b0;
                `TPT_IO_ONE: ch2_b_out <= 1'b1;
                `TPT_IO_TOGGLE: ch2_b_out <= ~ch2_b_out;
                default: ch2_b_out <= ch2_b_out;
            endcase
        end
    end
    // Ch2 B capture loads the B register: separate so writes stay simple
    reg [15:0] cap2b;
    always @(posedge clk)
    begin
        if (!rst_n)
            cap2b <= `TPT_COUNT_ZERO;
        else if (ch2_cap)
            cap2b <= count[2];
    end
    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @*
    begin
        next_readdata = `TPT_WORD_ZERO;
        case (address)
            `TPT_CH0_CONTROL: next_readdata[7:0] = control[0];
            `TPT_CH0_MODE: next_readdata[7:0] = mode[0];
            `TPT_CH0_IO_HIGH: next_readdata[7:0] = io_control[0];
            `TPT_CH0_IO_LOW: next_readdata[7:0] = io_low0;
            `TPT_CH0_IRQ_ENABLE: next_readdata[7:0] = irq_enable[0];
            `TPT_CH0_FLAGS: next_readdata[7:0] = flags[0];
            `TPT_CH0_COUNT: next_readdata[15:0] = count[0];
            `TPT_CH1_CONTROL: next_readdata[7:0] = control[1];
            `TPT_CH1_MODE: next_readdata[7:0] = mode[1];
            `TPT_CH1_IO_CONTROL: next_readdata[7:0] = io_control[1];
            `TPT_CH1_IRQ_ENABLE: next_readdata[7:0] = irq_enable[1];
            `TPT_CH1_FLAGS: next_readdata[7:0] = flags[1];
            `TPT_CH1_COUNT: next_readdata[15:0] = count[1];
            `TPT_CH2_CONTROL: next_readdata[7:0] = control[2];
            `TPT_CH2_MODE: next_readdata[7:0] = mode[2];
            `TPT_CH2_IO_CONTROL: next_readdata[7:0] = io_control[2];
            `TPT_CH2_IRQ_ENABLE: next_readdata[7:0] = irq_enable[2];
            `TPT_CH2_FLAGS: next_readdata[7:0] = flags[2];
            `TPT_CH2_COUNT: next_readdata[15:0] = count[2];
            `TPT_SYNC_REG: next_readdata[2:0] = sync_reg;
            `TPT_IRQ_STATUS: next_readdata[2:0] = irq_status;
            `TPT_IRQ_MASK: next_readdata[2:0] = irq_mask;
            `TPT_GRC0: next_readdata[15:0] = grc0;
            `TPT_GRD0: next_readdata[15:0] = grd0;
            `TPT_GRA_BASE: next_readdata[15:0] = gra[0];
            `TPT_GRA_BASE + `TPT_GR_STRIDE: next_readdata[15:0] = gra[1];
            `TPT_GRA_BASE + 2 * `TPT_GR_STRIDE: next_readdata[15:0] = gra[2];
            `TPT_GRB_BASE: next_readdata[15:0] = grb[0];
            `TPT_GRB_BASE + `TPT_GR_STRIDE: next_readdata[15:0] = grb[1];
            `TPT_GRB_BASE + 2 * `TPT_GR_STRIDE: next_readdata[15:0] =
                io_control[2][`TPT_IO_CAPTURE_BIT] ? cap2b : grb[2];
            default: next_readdata = `TPT_BAD_DATA;
        endcase
    end
    // Registered read data, valid when waitrequest drops
    always @(posedge clk)
    begin
        if (!rst_n)
            readdata <= `TPT_WORD_ZERO;
        else if (read && !ack)
            readdata <= next_readdata;
    end
endmodule
`default_nettype wire

// [rtl/tpt_defines.vh]
// Constants, register map and field layout of the three channel pulse timer
// How it works
// - Two-bit clear field selects clear source
// - Sync bit gates synchronous clearing participation
// - Counter wrap FFFF to 0000 sets overflow
// - Overflow cleared by zero write after read
// - Flags accept only zero writes, clearing
// - Enable bit gates A/D start requests
// - Channels 1,2 count down only in phase or cascade mode
// - Channel 2 B compare: initial level, match action
// - Channel 2 B capture: rising, falling, both
// - Channel 0 D buffer ignores its I/O control
// - C or D buffer acts purely as buffer
// - Channel 1 capture may use ch0 C event
// - Buffer C/D events never clear counter
`ifndef TPT_DEFINES_VH
`define TPT_DEFINES_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TPT_CH0_CONTROL 16'hFFD0
`define TPT_CH0_MODE 16'hFFD1
`define TPT_CH0_IO_HIGH 16'hFFD2
`define TPT_CH0_IO_LOW 16'hFFD3
`define TPT_CH0_IRQ_ENABLE 16'hFFD4
`define TPT_CH0_FLAGS 16'hFFD5
`define TPT_CH0_COUNT 16'hFFD6
`define TPT_CH1_CONTROL 16'hFFE0
`define TPT_CH1_MODE 16'hFFE1
`define TPT_CH1_IO_CONTROL 16'hFFE2
`define TPT_CH1_IRQ_ENABLE 16'hFFE4
`define TPT_CH1_FLAGS 16'hFFE5
`define TPT_CH1_COUNT 16'hFFE6
`define TPT_CH2_CONTROL 16'hFFF0
`define TPT_CH2_MODE 16'hFFF1
`define TPT_CH2_IO_CONTROL 16'hFFF2
`define TPT_CH2_IRQ_ENABLE 16'hFFF4
`define TPT_CH2_FLAGS 16'hFFF5
`define TPT_CH2_COUNT 16'hFFF6
`define TPT_SYNC_REG 16'hFF80
`define TPT_GRA_BASE 16'hFF90
`define TPT_GRB_BASE 16'hFFA0
`define TPT_GRC0 16'hFFB0
`define TPT_GRD0 16'hFFB4
`define TPT_IRQ_STATUS 16'hFFB8
`define TPT_IRQ_MASK 16'hFFBC
`define TPT_CH_STRIDE 16'h0010
`define TPT_GR_STRIDE 16'h0004
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define TPT_CCLR_NONE 2'h0
`define TPT_CCLR_A 2'h1
`define TPT_CCLR_B 2'h2
`define TPT_CCLR_SYNC 2'h3
`define TPT_CCLR_HI 7
`define TPT_CCLR_LO 6
`define TPT_CCLR_C_BIT 5
`define TPT_MODE_PHASE_BIT 2
`define TPT_MODE_EXT_BIT 1
`define TPT_MODE_DOWN_BIT 0
`define TPT_MODE_BUFD_BIT 5
`define TPT_MODE_BUFC_BIT 4
`define TPT_MODE_RSV_BIT 3
`define TPT_IO_CAPTURE_BIT 3
`define TPT_IO_INIT_BIT 2
`define TPT_IO_BOTH_BIT 1
`define TPT_IO_LOW_HI 1
`define TPT_IO_ZERO 2'h1
`define TPT_IO_ONE 2'h2
`define TPT_IO_TOGGLE 2'h3
`define TPT_IO_OFF 2'h0
`define TPT_IO1_SRC_BIT 7
`define TPT_ADC_EN_BIT 7
`define TPT_OVF_EN_BIT 4
`define TPT_OVF_BIT 4
`define TPT_MATCH_A_BIT 0
`define TPT_MATCH_B_BIT 1
`define TPT_COUNT_MAX 16'hFFFF
`define TPT_COUNT_ZERO 16'h0000
`define TPT_BYTE_ZERO 8'h00
`define TPT_WORD_ZERO 32'h00000000
`define TPT_BAD_DATA 32'hDEADBEEF
`endif

// [sim/tpt_timer_sva.sv]
// Port-level assertions for the three channel pulse timer
`timescale 1ns/1ps
`default_nettype none
module tpt_timer_sva
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pins and requests
    input wire logic ch2_b_oe,
    input wire logic [2:0] adc_start,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // First cycle of a request always stalls
    property p_wait_first;
        (read || write) && !$past(read || write) |-> waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    // Exactly one wait state
    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest || !(read || write);
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state too long");
    // No stall without a request
    property p_wait_idle;
        !(read || write) |-> !waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("stall while idle");
    // Read data holds between reads
    property p_rd_stand;
        !read |=> $stable(readdata);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    // Unmapped read answers the filler word
    property p_unmapped;
        read && !waitrequest && address == 16'h0000 |-> readdata == 32'hDEADBEEF;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad unmapped data");
    // Channel 0 A/D start is a single-cycle pulse
    property p_adc_pulse;
        adc_start[0] |=> !adc_start[0];
    endproperty
    a_adc_pulse: assert property (p_adc_pulse) else $error("adc start too long");
    // Output enable moves only after an I/O control write
    property p_oe_change;
        $changed(ch2_b_oe) |-> $past(write && !waitrequest && address == 16'hFFF2, 2);
    endproperty
    a_oe_change: assert property (p_oe_change) else $error("enable moved alone");
    // Interrupt drops only after a register write
    property p_irq_fall;
        $fell(irq) |-> $past(write) || $past(write, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule
bind tpt_timer tpt_timer_sva chk (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .ch2_b_oe(ch2_b_oe),
    .adc_start(adc_start), .irq(irq));
`default_nettype wire

// [sim/tpt_pins_model.sv]
// Pin-side model: capture pin, count direction and A/D trigger tally
`timescale 1ns/1ps
`default_nettype none
module tpt_pins_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device requests
    input wire logic [2:0] adc_start,
    // Pins into the device
    output var logic [2:0] count_down_pin,
    output var logic ch1_a_pin,
    output var logic ch2_b_pin,
    // Trigger tally
    output var logic [15:0] adc_hits
);
    // Quiet pins at start
    initial
    begin
        count_down_pin = 3'h0;
        ch1_a_pin = 1'b0;
        ch2_b_pin = 1'b0;
    end
    // Count channel 0 A/D start pulses
    always @(posedge clk)
    begin
        if (!rst_n)
            adc_hits <= 16'h0000;
        else if (adc_start[0])
            adc_hits <= adc_hits + 16'h0001;
    end
    // Pin drivers, changed just after an edge
    task set_b(input logic v);
        @(posedge clk);
        ch2_b_pin <= v;
    endtask
    task set_dir(input logic [2:0] v);
        @(posedge clk);
        count_down_pin <= v;
    endtask
endmodule
`default_nettype wire

// [sim/tpt_timer_tb_top.sv]
// Self-checking testbench of the three channel pulse timer
`timescale 1ns/1ps
`default_nettype none
module tpt_timer_tb_top;
    logic clk, rst_n, read, write, waitrequest, ch1_a_pin, ch2_b_pin, ch2_b_out, ch2_b_oe, irq;
    logic [15:0] address, adc_hits, hits0;
    logic [31:0] writedata, readdata, q;
    logic [2:0] count_down_pin, adc_start, chan_irq;
    int num_errors, n_checks, i;
    tpt_timer uut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .count_down_pin(count_down_pin), .ch1_a_pin(ch1_a_pin), .ch2_b_pin(ch2_b_pin),
        .ch2_b_out(ch2_b_out), .ch2_b_oe(ch2_b_oe), .adc_start(adc_start),
        .chan_irq(chan_irq), .irq(irq));
    tpt_pins_model pins (.clk(clk), .rst_n(rst_n), .adc_start(adc_start),
        .count_down_pin(count_down_pin), .ch1_a_pin(ch1_a_pin), .ch2_b_pin(ch2_b_pin),
        .adc_hits(adc_hits));
    // 125 MHz clock
    always #4 clk = ~clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task end_sim;
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_checks++;
        if ((got & m) !== (exp & m))
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got & m, exp & m);
            num_errors++;
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (waitrequest !== 1'b0)
        begin
            num_errors++;
            end_sim;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    function automatic logic probe(input int sel);
        case (sel)
            0: probe = chan_irq[0];
            1: probe = ch2_b_out;
            default: probe = (adc_hits != hits0);
        endcase
    endfunction
    // Bounded wait on a device output
    task wait_for(input int sel, input logic v);
        int n;
        n = 0;
        while (probe(sel) !== v && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        if (probe(sel) !== v)
        begin
            num_errors++;
            end_sim;
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 16'h0000;
        writedata = 32'h00000000;
        num_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 16'h0000, 32'h0);
        chk(q, 32'hDEADBEEF, 32'hFFFFFFFF);
        bus(1, 16'hFFE5, 32'hFF);
        bus(0, 16'hFFE5, 32'h0);
        chk(q, 32'h0, 32'h10);
        // Overflow flag, interrupt and clearing
        bus(1, 16'hFFD4, 32'h10);
        bus(1, 16'hFFD6, 32'hFFF0);
        wait_for(0, 1'b1);
        bus(1, 16'hFFD5, 32'h0);
        bus(0, 16'hFFD5, 32'h0);
        chk(q, 32'h10, 32'h10);
        bus(1, 16'hFFD5, 32'h0);
        bus(0, 16'hFFD5, 32'h0);
        chk(q, 32'h0, 32'h10);
        chk({31'h0, chan_irq[0]}, 32'h0, 32'h1);
        bus(0, 16'hFFB8, 32'h0);
        chk(q, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h0, 32'h1);
        bus(1, 16'hFFBC, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        bus(1, 16'hFFB8, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        // A/D start and clear on A match
        bus(1, 16'hFF90, 32'h40);
        bus(1, 16'hFFD0, 32'h40);
        bus(1, 16'hFFD4, 32'h80);
        hits0 = adc_hits;
        wait_for(2, 1'b1);
        bus(0, 16'hFFD6, 32'h0);
        chk({31'h0, q[15:0] <= 16'h0040}, 32'h1, 32'h1);
        bus(1, 16'hFFD4, 32'h0);
        @(negedge clk);
        hits0 = adc_hits;
        repeat (200) @(posedge clk);
        chk({16'h0, adc_hits}, {16'h0, hits0}, 32'hFFFF);
        // D as buffer never clears the counter
        bus(1, 16'hFFB4, 32'h20);
        bus(1, 16'hFFD1, 32'h20);
        bus(1, 16'hFFD0, 32'hA0);
        bus(1, 16'hFFD6, 32'h0);
        repeat (100) @(posedge clk);
        bus(0, 16'hFFD6, 32'h0);
        chk({31'h0, q[15:0] > 16'h0030}, 32'h1, 32'h1);
        // Count direction of channel 1
        pins.set_dir(3'h2);
        bus(1, 16'hFFE6, 32'h1000);
        repeat (50) @(posedge clk);
        bus(0, 16'hFFE6, 32'h0);
        chk({31'h0, q[15:0] > 16'h1000}, 32'h1, 32'h1);
        bus(1, 16'hFFE1, 32'h04);
        bus(1, 16'hFFE6, 32'h1000);
        repeat (50) @(posedge clk);
        bus(0, 16'hFFE6, 32'h0);
        chk({31'h0, q[15:0] < 16'h1000}, 32'h1, 32'h1);
        // Channel 1 capture from channel 0 C event
        bus(1, 16'hFFE5, 32'h0);
        bus(1, 16'hFFE2, 32'h80);
        bus(1, 16'hFFB0, 32'h10);
        bus(1, 16'hFFD6, 32'h0);
        repeat (30) @(posedge clk);
        bus(0, 16'hFFE5, 32'h0);
        chk(q, 32'h1, 32'h1);
        // Channel 2 B compare output codes
        bus(1, 16'hFFA8, 32'h100);
        for (i = 0; i < 2; i++)
        begin
            bus(1, 16'hFFF6, 32'h0);
            bus(1, 16'hFFF2, i ? 32'h5 : 32'h2);
            repeat (2) @(negedge clk);
            chk({30'h0, ch2_b_oe, ch2_b_out}, {30'h0, 1'b1, i[0]}, 32'h3);
            wait_for(1, !i[0]);
        end
        bus(1, 16'hFFF2, 32'h0);
        repeat (2) @(negedge clk);
        chk({31'h0, ch2_b_oe}, 32'h0, 32'h1);
        // Channel 2 B capture on rising, falling, both edges
        for (i = 0; i < 3; i++)
        begin
            bus(1, 16'hFFF2, 32'h8 + i);
            bus(1, 16'hFFF6, (i + 1) * 32'h1000);
            pins.set_b(!i[0]);
            repeat (10) @(posedge clk);
            bus(0, 16'hFFA8, 32'h0);
            chk({31'h0, q[15:12] == i + 1}, 32'h1, 32'h1);
        end
        end_sim;
    end
endmodule
`default_nettype wire
